// ### inc/ism_pkg.sv
package ism_pkg;

    // ****************************************************************
    // timer states, gray coded
    // ****************************************************************
    typedef enum logic [1:0]
    {
        TMR_IDLE = 2'h0,
        TMR_RUN = 2'h1,
        TMR_EXP = 2'h3
    } ism_tmr_state_t;

    // ****************************************************************
    // decoded register select
    // ****************************************************************
    typedef enum logic [2:0]
    {
        REG_MASK3 = 3'h0,
        REG_STAT3 = 3'h1,
        REG_TIMER = 3'h2,
        REG_EVT = 3'h3,
        REG_EVTMSK = 3'h4,
        REG_MODE = 3'h5,
        REG_NONE = 3'h7
    } ism_reg_t;

    typedef logic [7:0] ism_byte_t;

endpackage

// ### inc/ism_regs.svh
`ifndef ISM_REGS_SVH
`define ISM_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ISM_OFF_MASK3 8'h00
`define ISM_OFF_STAT3 8'h04
`define ISM_OFF_TIMER 8'h08
`define ISM_OFF_EVT 8'h0C
`define ISM_OFF_EVTMSK 8'h10
`define ISM_OFF_MODE 8'h14

// ****************************************************************
// status and mask bit positions
// ****************************************************************
`define ISM_B_DONE 0
`define ISM_B_TLC 1
`define ISM_B_NEF 2
`define ISM_B_NFF 3
`define ISM_B_STOP 4
`define ISM_B_DONTCARE 5
`define ISM_B_SRC2 6
`define ISM_B_INT 7
// mask bits that can raise the request
`define ISM_MASK3_LIVE 8'h5F
`define ISM_MASK3_RST 8'h00

// ****************************************************************
// event bit positions
// ****************************************************************
`define ISM_E_TMO 0
`define ISM_E_ATN 1
`define ISM_EVT_W 2
`define ISM_EVT_RST 2'h0
`define ISM_MODE_B_LEGACY 0
`define ISM_MODE_RST 1'h0

// ****************************************************************
// timing
// ****************************************************************
`define ISM_CLK_NS 10
`define ISM_TICK_NS 1000
`define ISM_TICK_CYC (`ISM_TICK_NS / `ISM_CLK_NS)

// ****************************************************************
// bus answers
// ****************************************************************
`define ISM_RESP_OKAY 2'h0
`define ISM_RESP_SLVERR 2'h2
`define ISM_RDATA_RST 32'h0000_0000

`endif

// ### inc/ism_tmr_if.sv
`timescale 1ns/10ps
interface ism_tmr_if #(parameter int TMR_W = 16);
    logic load;
    logic [TMR_W-1:0] value;
    logic [TMR_W-1:0] remain;
    logic expire;
    logic running;

    modport ctl
    (
        output load,
        output value,
        input remain,
        input expire,
        input running
    );

    modport tmr
    (
        input load,
        input value,
        output remain,
        output expire,
        output running
    );
endinterface

// ### rtl/ism_irq3.sv
// Functional notes
// [RULE1] started timer sets timer_expired_flag once its interval elapses
// [RULE2] interrupt while timer_expired_flag and timer_expired_irq_enable both set
// [RULE3] timer register write clears timer_expired_flag
// [RULE4] enabled set status bit raises request pin and bit 7
// [RULE5] reset clears irq_mask_three, request pin deasserts
// [RULE6] irq_mask_three reads back the last value written
// [RULE7] single-chip: source two if unpaused and FIFO half full/empty by direction
// [RULE8] legacy modes: source two becomes 1 when ATN asserts
// [RULE9] status bit 3 reads 1 while the FIFOs are not full
// [RULE10] status bit 2 reads 1 while the FIFOs are not empty
// [RULE11] status bit 1 set on any enabled lower interrupt
// [RULE12] status bit 4 mirrors the transfer stop condition
// [RULE13] status bit 0 mirrors the transfer done condition
// [RULE14] host writes zero to mask bits 7 and 5; status bit 5 is don't-care
// [RULE15] request pin and summary bit are levels, no acknowledge
`timescale 1ns/10ps
`include "ism_regs.svh"
module ism_irq3
    import ism_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int TMR_W = 16,
    parameter int TICK_CYC = `ISM_TICK_CYC
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transfer engine conditions
    input wire logic xfer_inbound,
    input wire logic xfer_paused,
    input wire logic fifo_half_full,
    input wire logic fifo_half_empty,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic xfer_stop,
    input wire logic xfer_done,
    // gpib attention line, high while asserted
    input wire logic gpib_atn,
    // lower interrupt status and mask pairs
    input wire logic [7:0] lower_status_zero,
    input wire logic [7:0] lower_mask_zero,
    input wire logic [7:0] lower_status_one,
    input wire logic [7:0] lower_mask_one,
    input wire logic [7:0] lower_status_two,
    input wire logic [7:0] lower_mask_two,
    // host interrupt request
    output logic irq_req
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic ism_reg_t reg_sel(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        if (addr[1:0] != 2'h0)
            reg_sel = REG_NONE;
        else if (a == `ISM_OFF_MASK3)
            reg_sel = REG_MASK3;
        else if (a == `ISM_OFF_STAT3)
            reg_sel = REG_STAT3;
        else if (a == `ISM_OFF_TIMER)
            reg_sel = REG_TIMER;
        else if (a == `ISM_OFF_EVT)
            reg_sel = REG_EVT;
        else if (a == `ISM_OFF_EVTMSK)
            reg_sel = REG_EVTMSK;
        else if (a == `ISM_OFF_MODE)
            reg_sel = REG_MODE;
        else
            reg_sel = REG_NONE;
    endfunction

    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                m[8*i +: 8] = wd[8*i +: 8];
        end
        merge = m;
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    ism_tmr_if #(.TMR_W(TMR_W)) tif ();

    logic aw_hold_ff;
    logic w_hold_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    ism_byte_t mask3_ff;
    logic [`ISM_EVT_W-1:0] evt_ff;
    logic [`ISM_EVT_W-1:0] evtmsk_ff;
    logic legacy_ff;
    logic atn_prev_ff;
    logic irq_ff;

    logic wr_fire;
    logic rd_fire;
    ism_reg_t wr_sel;
    ism_reg_t rd_sel;
    logic [31:0] wr_word;
    logic [`ISM_EVT_W-1:0] evt_set;
    logic [`ISM_EVT_W-1:0] evt_clr;
    logic [`ISM_EVT_W-1:0] nxt_evt;
    logic src_two;
    logic tlc_irq;
    logic int_sum;
    ism_byte_t stat_raw;
    ism_byte_t stat3;
    logic nxt_irq;
    logic [31:0] rd_word;
    logic [31:0] tmr_word;

    // ****************************************************************
    // write channel, either order
    // ****************************************************************
    assign s_axi_awready = !aw_hold_ff;
    assign s_axi_wready = !w_hold_ff;
    assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_sel = reg_sel(awaddr_ff);
    assign wr_word = merge(32'h0000_0000, wdata_ff, wstrb_ff);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            awaddr_ff <= '0;
        end
        else if (s_axi_awvalid && !aw_hold_ff)
        begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_hold_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold_ff <= 1'b0;
            wdata_ff <= `ISM_RDATA_RST;
            wstrb_ff <= 4'h0;
        end
        else if (s_axi_wvalid && !w_hold_ff)
        begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_hold_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `ISM_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_sel == REG_NONE) ? `ISM_RESP_SLVERR : `ISM_RESP_OKAY;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mask3_ff <= `ISM_MASK3_RST; // [RULE5]
        else if (wr_fire && wr_sel == REG_MASK3 && wstrb_ff[0])
            mask3_ff <= wr_word[7:0]; // [RULE6]
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            evtmsk_ff <= `ISM_EVT_RST;
        else if (wr_fire && wr_sel == REG_EVTMSK && wstrb_ff[0])
            evtmsk_ff <= wr_word[`ISM_EVT_W-1:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            legacy_ff <= `ISM_MODE_RST;
        else if (wr_fire && wr_sel == REG_MODE && wstrb_ff[0])
            legacy_ff <= wr_word[`ISM_MODE_B_LEGACY];
    end

    // ****************************************************************
    // timer, restarted by any write to the timer register
    // ****************************************************************
    assign tif.load = wr_fire && wr_sel == REG_TIMER;
    assign tmr_word = merge(32'(tif.remain), wdata_ff, wstrb_ff);
    assign tif.value = tmr_word[TMR_W-1:0];

    ism_timer #(
        .TMR_W(TMR_W),
        .TICK_CYC(TICK_CYC)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tif(tif)
    );

    // ****************************************************************
    // sticky events, set wins over clear
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            atn_prev_ff <= 1'b0;
        else
            atn_prev_ff <= gpib_atn;
    end

    always_comb
    begin
        evt_set = '0;
        evt_set[`ISM_E_TMO] = tif.expire; // [RULE1]
        evt_set[`ISM_E_ATN] = legacy_ff && gpib_atn && !atn_prev_ff; // [RULE8]
        evt_clr = '0;
        if (wr_fire && wr_sel == REG_EVT && wstrb_ff[0])
            evt_clr = wr_word[`ISM_EVT_W-1:0];
        if (tif.load)
            evt_clr[`ISM_E_TMO] = 1'b1; // [RULE3]
        nxt_evt = (evt_ff & ~evt_clr) | evt_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            evt_ff <= `ISM_EVT_RST;
        else
            evt_ff <= nxt_evt;
    end

    // ****************************************************************
    // irq_status_three assembly
    // ****************************************************************
    always_comb
    begin
        tlc_irq = |(lower_status_zero & lower_mask_zero)
                | |(lower_status_one & lower_mask_one)
                | |(lower_status_two & lower_mask_two); // [RULE11]
        if (legacy_ff)
            src_two = evt_ff[`ISM_E_ATN]; // [RULE8]
        else
            src_two = !xfer_paused && (xfer_inbound ? fifo_half_full : fifo_half_empty); // [RULE7]
        stat_raw = 8'h00;
        stat_raw[`ISM_B_DONE] = xfer_done; // [RULE13]
        stat_raw[`ISM_B_TLC] = tlc_irq;
        stat_raw[`ISM_B_NEF] = !fifo_empty; // [RULE10]
        stat_raw[`ISM_B_NFF] = !fifo_full; // [RULE9]
        stat_raw[`ISM_B_STOP] = xfer_stop; // [RULE12]
        stat_raw[`ISM_B_SRC2] = src_two;
        // bits 7 and 5 of the mask never take part
        int_sum = |(stat_raw & mask3_ff & `ISM_MASK3_LIVE); // [RULE4] [RULE14]
        stat3 = stat_raw;
        stat3[`ISM_B_INT] = int_sum; // [RULE4] [RULE15]
        nxt_irq = int_sum || |(evt_ff & evtmsk_ff); // [RULE2]
    end

    // ****************************************************************
    // interrupt output
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_ff <= 1'b0; // [RULE5]
        else
            irq_ff <= nxt_irq; // [RULE15]
    end

    assign irq_req = irq_ff;

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign s_axi_arready = !rvalid_ff;
    assign rd_fire = s_axi_arvalid && !rvalid_ff;
    assign rd_sel = reg_sel(s_axi_araddr);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            REG_MASK3: rd_word[7:0] = mask3_ff; // [RULE6]
            REG_STAT3: rd_word[7:0] = stat3;
            REG_TIMER: rd_word[TMR_W-1:0] = tif.remain;
            REG_EVT: rd_word[`ISM_EVT_W-1:0] = evt_ff;
            REG_EVTMSK: rd_word[`ISM_EVT_W-1:0] = evtmsk_ff;
            REG_MODE: rd_word[`ISM_MODE_B_LEGACY] = legacy_ff;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `ISM_RESP_OKAY;
            rdata_ff <= `ISM_RDATA_RST;
        end
        else if (rd_fire)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= (rd_sel == REG_NONE) ? `ISM_RESP_SLVERR : `ISM_RESP_OKAY;
            rdata_ff <= rd_word;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

endmodule // ism_irq3

// ### rtl/ism_timer.sv
`timescale 1ns/10ps
`include "ism_regs.svh"
module ism_timer
    import ism_pkg::*;
#(
    parameter int TMR_W = 16,
    parameter int TICK_CYC = `ISM_TICK_CYC
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control side
    ism_tmr_if.tmr tif
);

    localparam int PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

    ism_tmr_state_t state_ff;
    logic [PW-1:0] pre_ff;
    logic [TMR_W-1:0] remain_ff;
    logic expire_ff;
    logic tick;

    // ****************************************************************
    // prescaler tick, restarted on load
    // ****************************************************************
    assign tick = (pre_ff == PW'(TICK_CYC - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn || tif.load || tick)
            pre_ff <= '0;
        else if (state_ff == TMR_RUN)
            pre_ff <= pre_ff + PW'(1);
    end

    // ****************************************************************
    // countdown; a value of 0 acts as 1
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= TMR_IDLE;
            remain_ff <= '0;
            expire_ff <= 1'b0;
        end
        else
        begin
            expire_ff <= 1'b0;
            case (state_ff)
                TMR_IDLE, TMR_EXP:
                begin
                    if (tif.load)
                    begin
                        state_ff <= TMR_RUN;
                        remain_ff <= tif.value;
                    end
                end
                TMR_RUN:
                begin
                    if (tif.load)
                        remain_ff <= tif.value;
                    else if (tick)
                    begin
                        if (remain_ff <= TMR_W'(1))
                        begin
                            remain_ff <= '0;
                            expire_ff <= 1'b1; // [RULE1]
                            state_ff <= TMR_EXP;
                        end
                        else
                            remain_ff <= remain_ff - TMR_W'(1);
                    end
                end
                default:
                    state_ff <= TMR_IDLE;
            endcase
        end
    end

    assign tif.remain = remain_ff;
    assign tif.expire = expire_ff;
    assign tif.running = (state_ff == TMR_RUN);

endmodule // ism_timer

// ### tb/ism_host.sv
`timescale 1ns/10ps
`include "ism_regs.svh"
module ism_host
    import ism_pkg::*;
(
    // clock
    input wire logic aclk,
    // write channels
    output logic [7:0] s_axi_awaddr,
    output logic [2:0] s_axi_awprot,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [7:0] s_axi_araddr,
    output logic [2:0] s_axi_arprot,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_bready} = '0;
        {s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= (a == `ISM_OFF_MASK3) ? (d & 32'h0000_005F) : d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok || s_axi_awready;
            w_ok = w_ok || s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // ism_host

// ### tb/ism_irq3_props.sv
`timescale 1ns/10ps
`include "ism_regs.svh"
module ism_irq3_props
    import ism_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // conditions and request
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic xfer_stop,
    input wire logic xfer_done,
    input wire logic irq_req
);
    logic [ADDR_W-1:0] aw_ff;
    logic [ADDR_W-1:0] ar_ff;
    logic [7:0] wd_ff;
    logic [7:0] mask_ff;
    logic bv_ff;
    logic [7:0] nxt_mask;
    logic [4:0] stat_lo;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // mask shadow
    // ****************************************************************
    assign stat_lo = {xfer_stop, !fifo_full, !fifo_empty, 1'b0, xfer_done};
    assign nxt_mask = (s_axi_bvalid && !bv_ff && aw_ff == `ISM_OFF_MASK3
                       && s_axi_bresp == `ISM_RESP_OKAY) ? wd_ff : mask_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mask_ff <= `ISM_MASK3_RST;
        else
            mask_ff <= nxt_mask;
    end

    always_ff @(posedge aclk)
    begin
        bv_ff <= aresetn && s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready)
            aw_ff <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            wd_ff <= s_axi_wdata[7:0];
        if (s_axi_arvalid && s_axi_arready)
            ar_ff <= s_axi_araddr;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    AST_RST_IRQ: assert property ($rose(aresetn) |-> !irq_req)
        else $error("irq after reset");
    AST_IRQ_SET: assert property (|(stat_lo & nxt_mask[4:0]) |=> irq_req)
        else $error("enabled bit, no irq");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read data");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("response dropped");
    AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second address taken");
    AST_MASK_RD: assert property ($rose(s_axi_rvalid) && ar_ff == `ISM_OFF_MASK3 |->
        s_axi_rdata == {24'h0000_00, mask_ff})
        else $error("mask readback");
    AST_STAT_RD: assert property ($rose(s_axi_rvalid) && ar_ff == `ISM_OFF_STAT3 |->
        (s_axi_rdata[4:0] & 5'h1D) == $past(stat_lo))
        else $error("status readback");
    AST_UNMAP: assert property ($rose(s_axi_bvalid) && aw_ff > 8'h14 |->
        s_axi_bresp == `ISM_RESP_SLVERR)
        else $error("unmapped write not refused");

    COV_IRQ_RISE: cover property ($rose(irq_req));
    COV_IRQ_FALL: cover property ($fell(irq_req));
    COV_SLVERR: cover property ($rose(s_axi_bvalid) && s_axi_bresp == `ISM_RESP_SLVERR);
endmodule // ism_irq3_props

bind ism_irq3 ism_irq3_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ### tb/tb_irq_status_mask_group_three.sv
`timescale 1ns/10ps
`include "ism_regs.svh"
module tb_irq_status_mask_group_three
    import ism_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_req;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic xfer_inbound = 1'b0, xfer_paused = 1'b1, fifo_half_full = 1'b0, fifo_half_empty = 1'b0;
    logic fifo_full = 1'b1, fifo_empty = 1'b1, xfer_stop = 1'b0, xfer_done = 1'b0, gpib_atn = 1'b0;
    logic [7:0] lower_status_zero = '0, lower_mask_zero = '0, lower_status_one = '0;
    logic [7:0] lower_mask_one = '0, lower_status_two = '0, lower_mask_two = '0;
    int bits [6] = '{0, 1, 2, 3, 4, 6};
    int fails = 0;
    int n_tests = 0;

    always #5 aclk = ~aclk;

    ism_irq3 #(.TICK_CYC(2)) uut (.*);
    ism_host host (.*);

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        host.rd(a, rv, rs);
        chk(what, exp, rv);
    endtask

    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, rs);
        chk("write response", `ISM_RESP_OKAY, rs);
        repeat (2) @(posedge aclk);
    endtask

    task automatic irq_is(input logic e);
        chk("irq_req", e, irq_req);
    endtask

    task automatic cond(input int i, input logic on);
        @(posedge aclk);
        case (i)
            0: xfer_done <= on;
            1:
            begin
                lower_status_one <= on ? 8'h10 : 8'h00;
                lower_mask_one <= 8'h10;
            end
            2: fifo_empty <= !on;
            3: fifo_full <= !on;
            4: xfer_stop <= on;
            default:
            begin
                xfer_inbound <= 1'b1;
                xfer_paused <= !on;
                fifo_half_full <= on;
            end
        endcase
        repeat (2) @(posedge aclk);
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        irq_is(1'b0);
        rchk("mask after reset", `ISM_OFF_MASK3, 32'h0);
        foreach (bits[k])
        begin
            cond(bits[k], 1'b1);
            wok(`ISM_OFF_MASK3, 32'h1 << bits[k]);
            irq_is(1'b1);
            rchk("status enabled", `ISM_OFF_STAT3, (32'h1 << bits[k]) | 32'h80);
            wok(`ISM_OFF_MASK3, 32'h0);
            irq_is(1'b0);
            rchk("status masked", `ISM_OFF_STAT3, 32'h1 << bits[k]);
            wok(`ISM_OFF_MASK3, 32'h1 << bits[k]);
            cond(bits[k], 1'b0);
            irq_is(1'b0);
            rchk("status cleared", `ISM_OFF_STAT3, 32'h0);
        end
        wok(`ISM_OFF_MASK3, 32'h5F);
        rchk("mask readback", `ISM_OFF_MASK3, 32'h5F);
        wok(`ISM_OFF_MASK3, 32'h0);
        @(posedge aclk);
        {xfer_inbound, xfer_paused, fifo_half_full, lower_status_zero, lower_mask_two} <= {3'h1, 16'h0102};
        rchk("outbound half full only", `ISM_OFF_STAT3, 32'h0);
        fifo_half_empty <= 1'b1;
        lower_status_two <= 8'h02;
        rchk("outbound half empty", `ISM_OFF_STAT3, 32'h42);
        xfer_paused <= 1'b1;
        rchk("paused", `ISM_OFF_STAT3, 32'h02);
        wok(`ISM_OFF_MODE, 32'h1);
        gpib_atn <= 1'b1;
        repeat (2) @(posedge aclk);
        gpib_atn <= 1'b0;
        rchk("legacy attention", `ISM_OFF_STAT3, 32'h42);
        wok(`ISM_OFF_EVT, 32'h2);
        wok(`ISM_OFF_MODE, 32'h0);
        wok(`ISM_OFF_EVTMSK, 32'h1);
        wok(`ISM_OFF_TIMER, 32'h8);
        rchk("timer running", `ISM_OFF_EVT, 32'h0);
        repeat (20) @(posedge aclk);
        rchk("timer expired", `ISM_OFF_EVT, 32'h1);
        irq_is(1'b1);
        wok(`ISM_OFF_TIMER, 32'h100);
        rchk("timer write clears", `ISM_OFF_EVT, 32'h0);
        irq_is(1'b0);
        host.wr(8'h18, 32'h1, rs);
        chk("unmapped write", `ISM_RESP_SLVERR, rs);
        host.rd(8'h18, rv, rs);
        chk("unmapped read", {`ISM_RESP_SLVERR, 32'h0}, {rs, rv});
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        conclude();
    end
endmodule // tb_irq_status_mask_group_three
